//--- bench/rmsp_checker.sv
// Concurrent checks on the ports of the RMS and apparent power stage.
module rmsp_checker (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire rmsp_pkg::rmsp_samples_t samples,
  input wire rmsp_pkg::rmsp_meter_out_t meter,
  input wire logic irq_n
);
  // Shadow of the mode register, snooped from committed writes.
  logic [23:0] mode_q;
  logic rd_status;
  assign rd_status = psel && penable && pready && !pwrite && paddr == rmsp_pkg::ADDR_STATUS;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_q <= '0;
    end else if (psel && penable && pready && pwrite && paddr == rmsp_pkg::ADDR_MODE) begin
      mode_q <= pwdata[23:0];
    end
  end
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_ready_first: assert property ((psel && !penable) ##1 (psel && penable) |-> pready)
    else $error("pready missing in first access cycle");
  a_ready_single: assert property (pready |=> !pready)
    else $error("pready held longer than one cycle");
  a_manual_phase: assert property (($stable(mode_q) && !mode_q[1]) |-> meter.use_phase_b == mode_q[0])
    else $error("phase select differs from mode bit 0");
  a_auto_larger: assert property ((mode_q[1] && mode_q[5] && meter.fault
    && !samples.active_power_a[23] && !samples.active_power_b[23]
    && $stable(samples.active_power_a) && $stable(samples.active_power_b))[*3]
    |-> meter.use_phase_b == (samples.active_power_b > samples.active_power_a))
    else $error("automatic switch did not pick the larger phase");
  a_creep_mode: assert property ($stable(mode_q) |-> meter.timed_creep_en == mode_q[6])
    else $error("anti-creep method differs from mode bit 6");
  a_status_clear: assert property (rd_status |=> !meter.irq_flags[0] && (!meter.irq_flags[1] || meter.fault))
    else $error("status flags survived a status read");
  a_irq_quiet: assert property ((meter.irq_flags == 2'b00)[*2] |-> irq_n)
    else $error("interrupt low with no status flag");
  a_fault_status: assert property ($rose(meter.fault) |-> ##[0:1] meter.irq_flags[1])
    else $error("fault rise did not set its status flag");
  a_reset_defaults: assert property ($rose(presetn) |-> !meter.use_phase_b && !meter.timed_creep_en && irq_n)
    else $error("outputs not at defaults after reset");
endmodule
bind rmsp_core rmsp_checker u_rmsp_checker (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .samples(samples), .meter(meter), .irq_n(irq_n));

//--- bench/rmsp_core_tb.sv
// Self-checking testbench for the RMS and apparent power stage.
module rmsp_core_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr, irq_n, last_err;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000, prdata, r;
  logic [63:0] note;
  logic signed [23:0] cur_a = 0, cur_b = 0, volt = 0, pow_a = 0, pow_b = 0;
  rmsp_pkg::rmsp_samples_t samples;
  rmsp_pkg::rmsp_meter_out_t meter;
  int miscompares = 0, n_checks = 0;
  int coef[4] = '{256, 128, 64, 207};
  int pw[4] = '{-5000, -5000, -5000, 5000};
  int ex[4] = '{5000, 0, -5000, 0};
  logic [63:0] notes[$];
  always #50 pclk = ~pclk;
  rmsp_front_model u_rmsp_front_model (.pclk(pclk), .cur_a(cur_a), .cur_b(cur_b), .volt(volt),
    .pow_a(pow_a), .pow_b(pow_b), .samples(samples));
  // Short filter shifts let the RMS settle within a few hundred cycles.
  rmsp_core #(.HPF_SHIFT(2), .LPF_SHIFT(2)) u_rmsp_core (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .samples(samples), .meter(meter), .irq_n(irq_n));
  task complete_run;
    $display("checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task chk(input string nm, input logic [31:0] e, input logic [31:0] s);
    n_checks++;
    if (s !== e) begin
      $display("mismatch %s expected %h seen %h", nm, e, s);
      miscompares++;
    end
  endtask
  // For reads d is the expected value and m the mask of bits that matter.
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [31:0] m = 32'h0000_0000);
    int n;
    if (!w) notes.push_back({m, d & m});
    @(posedge pclk);
    psel <= 1;
    penable <= 0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    last_err = pslverr;
    psel <= 0;
    penable <= 0;
    if (pready !== 1'b1) begin
      miscompares++;
      complete_run;
    end
  endtask
  task wt;
    repeat (6) @(posedge pclk);
  endtask
  always @(posedge pclk) begin
    if (psel && penable && pready === 1'b1 && !pwrite) begin
      note = notes.pop_front();
      chk($sformatf("read %h", paddr), note[31:0], prdata & note[63:32]);
    end
  end
  initial begin
    void'($urandom(32'h116b));
    repeat (5) @(posedge pclk);
    presetn <= 1;
    pow_a <= 24'sd300000;
    for (int a = 0; a <= 8'h2C; a += 4) apb(0, a[7:0], 0, 32'hFFFF_FFFF);
    apb(0, rmsp_pkg::ADDR_PF, 0, 32'hFFFF_FFFF);
    apb(0, rmsp_pkg::ADDR_ENERGY, 0, 32'hFFFF_FFFF);
    apb(0, 8'h48, 0, 32'hFFFF_FFFF);
    chk("unmapped error", 1, {31'h0, last_err});
    apb(1, 8'h01, 32'h0000_1234);
    chk("unaligned error", 1, {31'h0, last_err});
    apb(0, 8'h00, 0, 32'hFFFF_FFFF);
    $display("test reset and map done");
    for (int a = 0; a <= 8'h1C; a += 4) begin
      r = $urandom;
      apb(1, a[7:0], r);
      apb(0, a[7:0], r, 32'h0000_FFFF);
    end
    r = $urandom;
    apb(1, rmsp_pkg::ADDR_MODE, r);
    apb(0, rmsp_pkg::ADDR_MODE, r, 32'h0000_0F7F);
    $display("test readback done");
    for (int c = 0; c < 4; c++) begin
      apb(1, rmsp_pkg::ADDR_MODE, {20'h0, c[1:0], 10'h020});
      for (int k = 0; k < 2; k++) begin
        pow_b <= 24'sd204800;
        pow_a <= 24'(204800 - coef[c] * 100 + (k == 1 ? -100 : 100));
        wt;
        chk("fault", k, {31'h0, meter.fault});
      end
    end
    $display("test imbalance done");
    pow_a <= 24'sd1000;
    pow_b <= 24'sd100000;
    apb(1, rmsp_pkg::ADDR_MODE, 32'h0000_0022);
    wt;
    chk("phase b", 1, {31'h0, meter.use_phase_b});
    apb(1, rmsp_pkg::ADDR_MODE, 32'h0000_0020);
    wt;
    chk("phase b", 0, {31'h0, meter.use_phase_b});
    apb(1, rmsp_pkg::ADDR_MODE, 32'h0000_0021);
    wt;
    chk("phase b", 1, {31'h0, meter.use_phase_b});
    apb(1, rmsp_pkg::ADDR_MASK, 32'h0000_0002);
    wt;
    chk("irq", 0, {31'h0, irq_n});
    apb(0, rmsp_pkg::ADDR_STATUS, 32'h0000_0002, 32'h0000_0002);
    apb(0, rmsp_pkg::ADDR_STATUS, 0, 32'h0000_0003);
    wt;
    chk("irq", 1, {31'h0, irq_n});
    $display("test switching and status done");
    pow_b <= 24'sd0;
    for (int c = 0; c < 4; c++) begin
      apb(1, rmsp_pkg::ADDR_MODE, {22'h0, c[1:0], 8'h00});
      pow_a <= 24'(pw[c]);
      wt;
      chk("pulse power", ex[c], {{7{meter.pulse_power[24]}}, meter.pulse_power});
    end
    apb(1, rmsp_pkg::ADDR_CREEP, 32'd2000);
    apb(1, rmsp_pkg::ADDR_MODE, 32'h0000_0000);
    wt;
    chk("pulse power", 0, {{7{meter.pulse_power[24]}}, meter.pulse_power});
    apb(1, rmsp_pkg::ADDR_MODE, 32'h0000_0040);
    wt;
    chk("pulse power", 5000, {{7{meter.pulse_power[24]}}, meter.pulse_power});
    $display("test pulse feed done");
    apb(1, rmsp_pkg::ADDR_CREEP, 32'h0000_FFFF);
    apb(1, rmsp_pkg::ADDR_MODE, 32'h0000_001C);
    cur_a <= 24'sd40000;
    repeat (200) @(posedge pclk);
    apb(0, rmsp_pkg::ADDR_RMS_A, 0, 32'hFFFF_FFFF);
    $display("test rms creep done");
    complete_run;
  end
endmodule

//--- bench/rmsp_front_model.sv
// Converter front-end model: holds waveform and power values and strobes a sample every fourth cycle.
module rmsp_front_model (
  input wire logic pclk,
  input wire logic signed [23:0] cur_a,
  input wire logic signed [23:0] cur_b,
  input wire logic signed [23:0] volt,
  input wire logic signed [23:0] pow_a,
  input wire logic signed [23:0] pow_b,
  output rmsp_pkg::rmsp_samples_t samples
);
  timeunit 1ns;
  timeprecision 1ns;
  // A real converter strobes slower than the bus clock, so valid is sparse on purpose.
  logic [1:0] cnt = 2'h0;
  always @(posedge pclk) cnt <= cnt + 2'h1;
  assign samples = {cnt == 2'h0, cur_a, cur_b, volt, pow_a, pow_b};
endmodule

//--- core/rmsp_core.sv
// RMS, apparent power, apparent energy, power factor and working-mode control with an APB slave.
//
// Decided for this implementation: the APB interface to the registers and the register offsets.
module rmsp_core #(
  parameter int HPF_SHIFT = rmsp_pkg::HPF_SHIFT,
  parameter int LPF_SHIFT = rmsp_pkg::LPF_SHIFT
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire rmsp_pkg::rmsp_samples_t samples,
  output rmsp_pkg::rmsp_meter_out_t meter,
  output logic irq_n
);

  typedef struct packed {
    logic [2:0][23:0] dc;
    logic [2:0][47:0] ms;
    logic [2:0][23:0] rms;
    logic [2:0][15:0] rms_offset;
    logic [2:0][15:0] rms_gain;
    logic [15:0] va_offset;
    logic [15:0] va_gain;
    logic [23:0] mode;
    logic [15:0] creep;
    logic [1:0] mask;
    logic [1:0] status;
    logic signed [23:0] va;
    logic signed [48:0] energy;
    logic [23:0] pf;
    logic [3:0] tick;
    logic fault;
    logic use_b;
    logic signed [24:0] pulse_power;
    logic irq_n;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } rmsp_state_t;

  rmsp_state_t cur;
  rmsp_state_t next_cur;

  function automatic logic [23:0] rmsp_sqrt(input logic [47:0] v);
    logic [23:0] r;
    logic [23:0] t;
    logic [47:0] sq;
    r = 24'h00_0000;
    for (int k = 23; k >= 0; k--) begin
      t = r | (24'h00_0001 << k);
      sq = 48'(t) * 48'(t);
      if (sq <= v) begin
        r = t;
      end
    end
    return r;
  endfunction

  // Scales a non-negative magnitude by (1 + g / 2^16), saturating at full scale.
  function automatic logic [23:0] rmsp_gain(input logic [23:0] x, input logic [15:0] g);
    logic signed [42:0] xs;
    logic signed [42:0] fs;
    logic signed [42:0] p;
    xs = 43'(x);
    fs = 43'sh1_0000 + 43'($signed(g));
    p = (xs * fs) >>> rmsp_pkg::GAIN_SHIFT;
    if (p[42:24] != 19'h0_0000) begin
      return 24'hFF_FFFF;
    end
    return p[23:0];
  endfunction

  function automatic logic [23:0] rmsp_abs(input logic signed [23:0] x);
    logic signed [24:0] w;
    w = 25'(x);
    if (w < 0) begin
      w = -w;
    end
    if (w[24] || w[23]) begin
      return 24'h7F_FFFF;
    end
    return w[23:0];
  endfunction

  function automatic logic [31:0] rmsp_read(input rmsp_state_t s, input logic [7:0] a);
    case (a)
      rmsp_pkg::ADDR_RMS_OFFSET_A: return {16'h0000, s.rms_offset[0]};
      rmsp_pkg::ADDR_RMS_OFFSET_B: return {16'h0000, s.rms_offset[1]};
      rmsp_pkg::ADDR_RMS_OFFSET_V: return {16'h0000, s.rms_offset[2]};
      rmsp_pkg::ADDR_RMS_GAIN_A: return {16'h0000, s.rms_gain[0]};
      rmsp_pkg::ADDR_RMS_GAIN_B: return {16'h0000, s.rms_gain[1]};
      rmsp_pkg::ADDR_RMS_GAIN_V: return {16'h0000, s.rms_gain[2]};
      rmsp_pkg::ADDR_VA_OFFSET: return {16'h0000, s.va_offset};
      rmsp_pkg::ADDR_VA_GAIN: return {16'h0000, s.va_gain};
      rmsp_pkg::ADDR_MODE: return {8'h00, s.mode};
      rmsp_pkg::ADDR_CREEP: return {16'h0000, s.creep};
      rmsp_pkg::ADDR_MASK: return {30'h0000_0000, s.mask};
      rmsp_pkg::ADDR_STATUS: return {30'h0000_0000, s.status};
      rmsp_pkg::ADDR_RMS_A: return {8'h00, s.rms[0]};
      rmsp_pkg::ADDR_RMS_B: return {8'h00, s.rms[1]};
      rmsp_pkg::ADDR_RMS_V: return {8'h00, s.rms[2]};
      rmsp_pkg::ADDR_VA: return {8'h00, s.va};
      rmsp_pkg::ADDR_ENERGY: return {8'h00, s.energy[48:25]};
      rmsp_pkg::ADDR_PF: return {8'h00, s.pf};
      default: return 32'h0000_0000;
    endcase
  endfunction

  function automatic logic rmsp_mapped(input logic [7:0] a);
    return (a[1:0] == 2'b00) && (a <= rmsp_pkg::ADDR_PF);
  endfunction

  logic [2:0][23:0] raw_in;
  logic [2:0] bypass;
  logic signed [24:0] hp_out;
  logic signed [24:0] dc_step;
  logic [49:0] sq_full;
  logic signed [48:0] ms_step;
  logic signed [48:0] ms_corr;
  logic [23:0] rms_raw;
  logic [23:0] rms_gained;
  logic [25:0] creep_level;
  logic [47:0] va_prod;
  logic signed [25:0] va_sum;
  logic [23:0] va_mag;
  logic [23:0] cur_sel_rms;
  logic signed [23:0] p_sel;
  logic [23:0] qa;
  logic [23:0] qb;
  logic [23:0] q_big;
  logic [23:0] q_diff;
  logic [8:0] imb_coef;
  logic [35:0] lhs;
  logic [35:0] rhs;
  logic imbalance;
  logic signed [47:0] pf_num;
  logic signed [47:0] pf_q;
  logic signed [24:0] p_wide;
  logic [23:0] p_mag;
  logic msb_rise;
  logic access;
  logic rd_status;

  always_comb begin
    next_cur = cur;
    raw_in[0] = samples.current_a;
    raw_in[1] = samples.current_b;
    raw_in[2] = samples.voltage;
    bypass = cur.mode[rmsp_pkg::MODE_HPF_BYP +: 3];
    hp_out = 25'sh000_0000;
    dc_step = 25'sh000_0000;
    sq_full = 50'h0;
    ms_step = 49'sh0;
    ms_corr = 49'sh0;
    rms_raw = 24'h00_0000;
    rms_gained = 24'h00_0000;
    creep_level = {8'h00, cur.creep, 2'b00};

    // Each channel: optional high-pass, square, low-pass, then offset, root, gain and creep.
    for (int c = 0; c < 3; c++) begin
      if (samples.valid) begin
        dc_step = (25'($signed(raw_in[c])) - 25'($signed(cur.dc[c]))) >>> HPF_SHIFT;
        next_cur.dc[c] = 24'($signed(cur.dc[c]) + dc_step);
        if (bypass[c]) begin
          hp_out = 25'($signed(raw_in[c]));
        end else begin
          hp_out = 25'($signed(raw_in[c])) - 25'($signed(cur.dc[c]));
        end
        // Both factors are widened first so the square keeps all of its bits.
        sq_full = 50'(50'($signed(hp_out)) * 50'($signed(hp_out)));
        ms_step = ($signed({1'b0, sq_full[49:2]}) - $signed({1'b0, cur.ms[c]})) >>> LPF_SHIFT;
        next_cur.ms[c] = 48'($signed({1'b0, cur.ms[c]}) + ms_step);
      end
      ms_corr = $signed({1'b0, cur.ms[c]}) + ($signed(49'($signed(cur.rms_offset[c]))) <<< rmsp_pkg::OFFSET_SHIFT);
      if (ms_corr < 0) begin
        ms_corr = 49'sh0;
      end
      rms_raw = rmsp_sqrt(ms_corr[47:0]);
      rms_gained = rmsp_gain(rms_raw, cur.rms_gain[c]);
      if (26'(rms_gained) < creep_level) begin
        next_cur.rms[c] = 24'h00_0000;
      end else begin
        next_cur.rms[c] = rms_gained;
      end
    end

    // Imbalance check on currents or on phase power magnitudes.
    if (cur.mode[rmsp_pkg::MODE_CMP_POWER]) begin
      qa = rmsp_abs(samples.active_power_a);
      qb = rmsp_abs(samples.active_power_b);
    end else begin
      qa = cur.rms[0];
      qb = cur.rms[1];
    end
    q_big = (qa > qb) ? qa : qb;
    q_diff = (qa > qb) ? (qa - qb) : (qb - qa);
    case (cur.mode[rmsp_pkg::MODE_IMB_LO +: 2])
      2'b00: imb_coef = rmsp_pkg::IMB_COEF_00;
      2'b01: imb_coef = rmsp_pkg::IMB_COEF_01;
      2'b10: imb_coef = rmsp_pkg::IMB_COEF_10;
      default: imb_coef = rmsp_pkg::IMB_COEF_11;
    endcase
    lhs = {q_diff, 12'h000} >> 1;
    rhs = 36'(q_big) * 36'(imb_coef);
    imbalance = lhs > rhs;
    next_cur.fault = imbalance;

    // Automatic switching only overrides the manual pick while an imbalance stands.
    if (cur.mode[rmsp_pkg::MODE_AUTO] && imbalance) begin
      next_cur.use_b = qb > qa;
    end else begin
      next_cur.use_b = cur.mode[rmsp_pkg::MODE_SEL_B];
    end
    cur_sel_rms = cur.use_b ? cur.rms[1] : cur.rms[0];
    p_sel = cur.use_b ? samples.active_power_b : samples.active_power_a;

    // Apparent power: product, offset, then gain; negative results clip to zero.
    va_prod = 48'(cur_sel_rms) * 48'(cur.rms[2]);
    va_sum = 26'(va_prod[47:24]) + 26'($signed(cur.va_offset));
    if (va_sum < 0) begin
      va_mag = 24'h00_0000;
    end else if (va_sum[25:23] != 3'b000) begin
      va_mag = 24'h7F_FFFF;
    end else begin
      va_mag = va_sum[23:0];
    end
    va_mag = rmsp_gain(va_mag, cur.va_gain);
    next_cur.va = (va_mag[23]) ? 24'sh7F_FFFF : $signed(va_mag);

    // Energy integrates on the internal 1.1 us sample tick.
    if (cur.tick == 4'(rmsp_pkg::SAMPLE_CYCLES - 1)) begin
      next_cur.tick = 4'h0;
      next_cur.energy = cur.energy + 49'(cur.va);
    end else begin
      next_cur.tick = cur.tick + 4'h1;
    end
    msb_rise = next_cur.energy[48] && !cur.energy[48];

    // Power factor refreshed every cycle from the latest apparent power.
    pf_num = 48'(p_sel) <<< rmsp_pkg::PF_FRAC;
    pf_q = 48'sh0;
    if (cur.va == 24'sh00_0000) begin
      next_cur.pf = 24'h00_0000;
    end else begin
      pf_q = pf_num / 48'(cur.va);
      if (pf_q > 48'sh7F_FFFF) begin
        next_cur.pf = 24'h7F_FFFF;
      end else if (pf_q < -48'sh80_0000) begin
        next_cur.pf = 24'h80_0000;
      end else begin
        next_cur.pf = pf_q[23:0];
      end
    end

    // Feed to the pulse stage by accumulation mode and anti-creep method.
    p_wide = 25'(p_sel);
    p_mag = rmsp_abs(p_sel);
    case (cur.mode[rmsp_pkg::MODE_ACC_LO +: 2])
      2'b00: next_cur.pulse_power = 25'(p_mag);
      2'b01: next_cur.pulse_power = (p_wide > 0) ? p_wide : 25'sh000_0000;
      2'b10: next_cur.pulse_power = p_wide;
      default: next_cur.pulse_power = (p_wide < 0) ? -p_wide : 25'sh000_0000;
    endcase
    if (!cur.mode[rmsp_pkg::MODE_TIMED_CREEP] && (26'(p_mag) < creep_level)) begin
      next_cur.pulse_power = 25'sh000_0000;
    end

    // APB: setup registers the answer, the access edge commits the write or read side effect.
    access = psel && penable && cur.pready;
    rd_status = access && !pwrite && (paddr == rmsp_pkg::ADDR_STATUS);
    next_cur.pready = psel && !penable;
    next_cur.pslverr = psel && !penable && !rmsp_mapped(paddr);
    if (psel && !penable) begin
      next_cur.prdata = pwrite ? 32'h0000_0000 : rmsp_read(cur, paddr);
    end
    if (rd_status) begin
      next_cur.status = 2'b00;
    end
    if (access && pwrite) begin
      case (paddr)
        rmsp_pkg::ADDR_RMS_OFFSET_A: next_cur.rms_offset[0] = pwdata[15:0];
        rmsp_pkg::ADDR_RMS_OFFSET_B: next_cur.rms_offset[1] = pwdata[15:0];
        rmsp_pkg::ADDR_RMS_OFFSET_V: next_cur.rms_offset[2] = pwdata[15:0];
        rmsp_pkg::ADDR_RMS_GAIN_A: next_cur.rms_gain[0] = pwdata[15:0];
        rmsp_pkg::ADDR_RMS_GAIN_B: next_cur.rms_gain[1] = pwdata[15:0];
        rmsp_pkg::ADDR_RMS_GAIN_V: next_cur.rms_gain[2] = pwdata[15:0];
        rmsp_pkg::ADDR_VA_OFFSET: next_cur.va_offset = pwdata[15:0];
        rmsp_pkg::ADDR_VA_GAIN: next_cur.va_gain = pwdata[15:0];
        rmsp_pkg::ADDR_MODE: next_cur.mode = pwdata[23:0];
        rmsp_pkg::ADDR_CREEP: next_cur.creep = pwdata[15:0];
        rmsp_pkg::ADDR_MASK: next_cur.mask = pwdata[1:0];
        default: next_cur.mode = cur.mode;
      endcase
    end
    // A new event in the same cycle as the clearing read still lands.
    if (msb_rise) begin
      next_cur.status[rmsp_pkg::ST_HALF_FULL] = 1'b1;
    end
    if (imbalance && !cur.fault) begin
      next_cur.status[rmsp_pkg::ST_FAULT] = 1'b1;
    end
    next_cur.irq_n = !(|(next_cur.status & next_cur.mask));
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cur <= '0;
      cur.irq_n <= 1'b1;
      cur.mode <= rmsp_pkg::MODE_RESET;
      cur.va_offset <= rmsp_pkg::CFG_RESET;
    end else begin
      cur <= next_cur;
    end
  end

  assign prdata = cur.prdata;
  assign pready = cur.pready;
  assign pslverr = cur.pslverr;
  assign irq_n = cur.irq_n;
  assign meter.irq_flags = cur.status;
  assign meter.fault = cur.fault;
  assign meter.use_phase_b = cur.use_b;
  assign meter.timed_creep_en = cur.mode[rmsp_pkg::MODE_TIMED_CREEP];
  assign meter.pulse_power = cur.pulse_power;

endmodule

//--- pkg/rmsp_pkg.sv
// Shared constants, register map and carrier types for the RMS and apparent power stage.
// Operation
// - RMS by square, low-pass, square root
// - Signed offset added to square times 2^13
// - Signed gain scales RMS by one plus gain/2^16
// - RMS below creep times four reads zero
// - Apparent power is current RMS times voltage RMS
// - 49-bit accumulator every 1.1us, top 24 exposed
// - Apparent energy accumulates by signed addition
// - Energy top bit sets half-full flag, masked interrupt
// - Power factor is active over apparent, signed fraction
// - Signed apparent power offset added to raw value
// - Apparent power scaled by one plus gain/2^16
// - Mode bit 0 picks phase A or B
// - Mode bit 1 enables automatic switch to larger
// - Mode bits 2..4 bypass high-pass filters
// - Mode bits 9:8 pick pulse energy accumulation
// - Mode bits 11:10 pick imbalance threshold
// - Imbalance beyond threshold raises masked fault interrupt
// - Mode bit 5 compares currents or phase powers
// - Mode bit 6 picks threshold or timing anti-creep
// - Reading status clears its flags
package rmsp_pkg;
  localparam int DATA_W = 24;
  localparam int ENERGY_W = 49;
  localparam int OFFSET_SHIFT = 13;
  localparam int GAIN_SHIFT = 16;
  localparam int CREEP_SHIFT = 2;
  localparam int HPF_SHIFT = 10;
  localparam int LPF_SHIFT = 12;
  localparam int PF_FRAC = 23;
  localparam int IMB_SHIFT = 11;
  localparam int CLK_PERIOD_NS = 100;
  localparam int SAMPLE_PERIOD_NS = 1100;
  localparam int SAMPLE_CYCLES = (SAMPLE_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // Imbalance limits as fractions of 2048: 12.5, 6.25, 3.125 and 10.1 percent.
  localparam logic [8:0] IMB_COEF_00 = 9'h100;
  localparam logic [8:0] IMB_COEF_01 = 9'h080;
  localparam logic [8:0] IMB_COEF_10 = 9'h040;
  localparam logic [8:0] IMB_COEF_11 = 9'h0CF;

  localparam logic [7:0] ADDR_RMS_OFFSET_A = 8'h00;
  localparam logic [7:0] ADDR_RMS_OFFSET_B = 8'h04;
  localparam logic [7:0] ADDR_RMS_OFFSET_V = 8'h08;
  localparam logic [7:0] ADDR_RMS_GAIN_A = 8'h0C;
  localparam logic [7:0] ADDR_RMS_GAIN_B = 8'h10;
  localparam logic [7:0] ADDR_RMS_GAIN_V = 8'h14;
  localparam logic [7:0] ADDR_VA_OFFSET = 8'h18;
  localparam logic [7:0] ADDR_VA_GAIN = 8'h1C;
  localparam logic [7:0] ADDR_MODE = 8'h20;
  localparam logic [7:0] ADDR_CREEP = 8'h24;
  localparam logic [7:0] ADDR_MASK = 8'h28;
  localparam logic [7:0] ADDR_STATUS = 8'h2C;
  localparam logic [7:0] ADDR_RMS_A = 8'h30;
  localparam logic [7:0] ADDR_RMS_B = 8'h34;
  localparam logic [7:0] ADDR_RMS_V = 8'h38;
  localparam logic [7:0] ADDR_VA = 8'h3C;
  localparam logic [7:0] ADDR_ENERGY = 8'h40;
  localparam logic [7:0] ADDR_PF = 8'h44;

  localparam int MODE_SEL_B = 0;
  localparam int MODE_AUTO = 1;
  localparam int MODE_HPF_BYP = 2;
  localparam int MODE_CMP_POWER = 5;
  localparam int MODE_TIMED_CREEP = 6;
  localparam int MODE_ACC_LO = 8;
  localparam int MODE_IMB_LO = 10;
  localparam int ST_HALF_FULL = 0;
  localparam int ST_FAULT = 1;
  localparam logic [23:0] MODE_RESET = 24'h00_0000;
  localparam logic [15:0] CFG_RESET = 16'h0000;

  typedef struct packed {
    logic valid;
    logic signed [23:0] current_a;
    logic signed [23:0] current_b;
    logic signed [23:0] voltage;
    logic signed [23:0] active_power_a;
    logic signed [23:0] active_power_b;
  } rmsp_samples_t;

  typedef struct packed {
    logic [1:0] irq_flags;
    logic fault;
    logic use_phase_b;
    logic timed_creep_en;
    logic signed [24:0] pulse_power;
  } rmsp_meter_out_t;
endpackage
